// ### verilog/scp_pkg.sv
// serial control port package: frame layout, register map, reset values
// assumes a host that frames every transfer with an active-low chip select
package scp_pkg;
    localparam int HDR_W = 5;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int FRAME_BITS = HDR_W + ADDR_W + DATA_W;
    localparam int HDR_RD_POS = 4;
    localparam int AUX_W = 12;
    localparam int AUX_SEL_W = 3;
    localparam logic [4:0] CNT_ADDR_DONE = 5'h10;
    localparam logic [4:0] CNT_LAST = 5'h18;
    // register offsets
    localparam logic [ADDR_W-1:0] REG_PORT_CFG = 11'h000;
    localparam logic [ADDR_W-1:0] REG_AUX_CTRL = 11'h001;
    localparam logic [ADDR_W-1:0] REG_AUX_LO = 11'h002;
    localparam logic [ADDR_W-1:0] REG_AUX_HI = 11'h003;
    // fields
    localparam int CFG_THREE_WIRE_POS = 0;
    localparam int AUX_EN_POS = 0;
    localparam int AUX_SEL_LSB = 1;
    localparam logic [AUX_SEL_W-1:0] AUX_SEL_TEMP = 3'h4;
    // reset values
    localparam logic THREE_WIRE_RST = 1'b0;
    localparam logic [3:0] AUX_CTRL_RST = 4'h0;
    localparam logic [AUX_W-1:0] AUX_RST = 12'h000;

    function automatic logic hdr_is_read(input logic [HDR_W-1:0] hdr);
        return hdr[HDR_RD_POS];
    endfunction : hdr_is_read
endpackage : scp_pkg

// ### verilog/scp_regmem.sv
// byte-wide register store of the control port
// assumes one clock; read data registered when re is high
`timescale 1ns/100ps
`default_nettype none
module scp_regmem #(
    parameter int ADDR_W = 11,
    parameter int DATA_W = 8
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [DATA_W-1:0] wdata,
    // read side
    input wire logic re,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [DATA_W-1:0] rdata_ff;

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        if (re)
        begin
            rdata_ff <= mem[raddr];
        end
    end

    assign rdata = rdata_ff;
endmodule : scp_regmem
`default_nettype wire

// ### verilog/scp_top.sv
// serial control port: link shifter on the serial clock, aux converter control on core_clk
// assumes serial clock idles between frames; data sampled on rising, driven on falling edge
`timescale 1ns/100ps
`default_nettype none
module scp_top (
    // core clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // serial link
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_data_out_pin,
    output logic serial_data_out_oe,
    // aux converter
    input wire logic [scp_pkg::AUX_W-1:0] aux_result,
    input wire logic aux_result_valid,
    output logic aux_conv_enable,
    output logic [scp_pkg::AUX_SEL_W-1:0] aux_converter_input
);
    import scp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // link domain, rising edge
    logic frame_rst_n;
    logic [4:0] bit_cnt_ff, nxt_bit_cnt;
    logic [22:0] shin_ff, nxt_shin;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic rd_ff, nxt_rd;
    logic three_wire_ff, nxt_three_wire;
    logic [3:0] aux_ctrl_ff, nxt_aux_ctrl;
    logic ctl_tgl_ff, nxt_ctl_tgl;
    logic req_s1_ff, req_s2_ff, ack_ff, nxt_ack;
    logic req_ff;
    logic [AUX_W-1:0] aux_copy_ff, nxt_aux_copy;
    logic [AUX_W-1:0] snap_ff;
    logic mem_we, mem_re;
    logic [DATA_W-1:0] mem_q;

    // a frame ends the moment chip select rises
    assign frame_rst_n = rstn & ~spi_csn;

    always_comb
    begin
        nxt_shin = {shin_ff[21:0], sdio_in};
        nxt_bit_cnt = (bit_cnt_ff == CNT_LAST) ? bit_cnt_ff : bit_cnt_ff + 5'h01;
        nxt_addr = addr_ff;
        nxt_rd = rd_ff;
        mem_re = 1'b0;
        if (bit_cnt_ff == CNT_ADDR_DONE - 5'h01)
        begin
            nxt_rd = hdr_is_read(nxt_shin[15:11]);
            nxt_addr = nxt_shin[ADDR_W-1:0];
            mem_re = 1'b1;
        end
        // only a full 24-bit write frame commits
        mem_we = (bit_cnt_ff == CNT_LAST - 5'h01) && !rd_ff;
    end

    always_comb
    begin
        nxt_three_wire = three_wire_ff;
        nxt_aux_ctrl = aux_ctrl_ff;
        nxt_ctl_tgl = ctl_tgl_ff;
        nxt_ack = ack_ff;
        nxt_aux_copy = aux_copy_ff;
        if (mem_we && addr_ff == REG_PORT_CFG)
        begin
            nxt_three_wire = nxt_shin[CFG_THREE_WIRE_POS];
        end
        if (mem_we && addr_ff == REG_AUX_CTRL)
        begin
            nxt_aux_ctrl = nxt_shin[3:0];
            nxt_ctl_tgl = ~ctl_tgl_ff;
        end
        if (req_s2_ff != ack_ff)
        begin
            nxt_aux_copy = snap_ff;
            nxt_ack = req_s2_ff;
        end
    end

    always_ff @(posedge spi_sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            bit_cnt_ff <= 5'h00;
            shin_ff <= 23'h000000;
            addr_ff <= 11'h000;
            rd_ff <= 1'b0;
        end
        else
        begin
            bit_cnt_ff <= nxt_bit_cnt;
            shin_ff <= nxt_shin;
            addr_ff <= nxt_addr;
            rd_ff <= nxt_rd;
        end
    end

    always_ff @(posedge spi_sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            three_wire_ff <= THREE_WIRE_RST;
            aux_ctrl_ff <= AUX_CTRL_RST;
            ctl_tgl_ff <= 1'b0;
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            ack_ff <= 1'b0;
            aux_copy_ff <= AUX_RST;
        end
        else
        begin
            three_wire_ff <= nxt_three_wire;
            aux_ctrl_ff <= nxt_aux_ctrl;
            ctl_tgl_ff <= nxt_ctl_tgl;
            req_s1_ff <= req_ff;
            req_s2_ff <= req_s1_ff;
            ack_ff <= nxt_ack;
            aux_copy_ff <= nxt_aux_copy;
        end
    end

    scp_regmem #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_regmem (
        .clk(spi_sclk),
        .we(mem_we),
        .waddr(addr_ff),
        .wdata(nxt_shin[DATA_W-1:0]),
        .re(mem_re),
        .raddr(nxt_shin[ADDR_W-1:0]),
        .rdata(mem_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link domain, falling edge: read data out
    logic [DATA_W-1:0] out_sh_ff, nxt_out_sh;
    logic sdio_oe_ff, nxt_sdio_oe;
    logic sdo_oe_ff, nxt_sdo_oe;
    logic [DATA_W-1:0] rd_byte;

    always_comb
    begin
        unique case (addr_ff)
            REG_AUX_LO: rd_byte = aux_copy_ff[7:0];
            REG_AUX_HI: rd_byte = {4'h0, aux_copy_ff[AUX_W-1:8]};
            default: rd_byte = mem_q;
        endcase
        nxt_out_sh = out_sh_ff;
        nxt_sdio_oe = sdio_oe_ff;
        nxt_sdo_oe = sdo_oe_ff;
        if (bit_cnt_ff == CNT_ADDR_DONE && rd_ff)
        begin
            nxt_out_sh = rd_byte;
            nxt_sdio_oe = three_wire_ff;
            nxt_sdo_oe = ~three_wire_ff;
        end
        else if (bit_cnt_ff > CNT_ADDR_DONE && bit_cnt_ff < CNT_LAST)
        begin
            nxt_out_sh = {out_sh_ff[DATA_W-2:0], 1'b0};
        end
        else if (bit_cnt_ff == CNT_LAST)
        begin
            nxt_sdio_oe = 1'b0;
            nxt_sdo_oe = 1'b0;
        end
    end

    always_ff @(negedge spi_sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            out_sh_ff <= 8'h00;
            sdio_oe_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end
        else
        begin
            out_sh_ff <= nxt_out_sh;
            sdio_oe_ff <= nxt_sdio_oe;
            sdo_oe_ff <= nxt_sdo_oe;
        end
    end

    assign sdio_out = out_sh_ff[DATA_W-1];
    assign serial_data_out_pin = out_sh_ff[DATA_W-1];
    assign sdio_oe = sdio_oe_ff;
    assign serial_data_out_oe = sdo_oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // core domain: aux converter control and result latch
    logic ctl_s1_ff, ctl_s2_ff, ctl_seen_ff;
    logic aux_en_ff, nxt_aux_en;
    logic [AUX_SEL_W-1:0] aux_sel_ff, nxt_aux_sel;
    logic [AUX_W-1:0] aux_latch_ff, nxt_aux_latch;
    logic [AUX_W-1:0] nxt_snap;
    logic nxt_req;
    logic ack_s1_ff, ack_s2_ff;

    always_comb
    begin
        nxt_aux_en = aux_en_ff;
        nxt_aux_sel = aux_sel_ff;
        nxt_aux_latch = aux_latch_ff;
        nxt_snap = snap_ff;
        nxt_req = req_ff;
        // shadow is stable long before the next write can land
        if (ctl_s2_ff != ctl_seen_ff)
        begin
            nxt_aux_en = aux_ctrl_ff[AUX_EN_POS];
            // codes above the temperature diode fall back to it
            nxt_aux_sel = (aux_ctrl_ff[3:AUX_SEL_LSB] > AUX_SEL_TEMP) ? AUX_SEL_TEMP
                : aux_ctrl_ff[3:AUX_SEL_LSB];
        end
        if (aux_en_ff && aux_result_valid)
        begin
            nxt_aux_latch = aux_result;
        end
        if (req_ff == ack_s2_ff)
        begin
            nxt_snap = aux_latch_ff;
            nxt_req = ~req_ff;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            ctl_s1_ff <= 1'b0;
            ctl_s2_ff <= 1'b0;
            ctl_seen_ff <= 1'b0;
            aux_en_ff <= AUX_CTRL_RST[AUX_EN_POS];
            aux_sel_ff <= AUX_CTRL_RST[3:AUX_SEL_LSB];
            aux_latch_ff <= AUX_RST;
            snap_ff <= AUX_RST;
            req_ff <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end
        else
        begin
            ctl_s1_ff <= ctl_tgl_ff;
            ctl_s2_ff <= ctl_s1_ff;
            ctl_seen_ff <= ctl_s2_ff;
            aux_en_ff <= nxt_aux_en;
            aux_sel_ff <= nxt_aux_sel;
            aux_latch_ff <= nxt_aux_latch;
            snap_ff <= nxt_snap;
            req_ff <= nxt_req;
            ack_s1_ff <= ack_ff;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    assign aux_conv_enable = aux_en_ff;
    assign aux_converter_input = aux_sel_ff;
endmodule : scp_top
`default_nettype wire

// ### bench/scp_chk.sv
// checker of the control port pins, bound into scp_top
// assumes the serial clock idles between frames
`timescale 1ns/100ps
`default_nettype none
module scp_chk (
    // clocks and reset
    input wire logic core_clk,
    input wire logic rstn,
    // serial link
    input wire logic spi_sclk,
    input wire logic spi_csn,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_data_out_pin,
    input wire logic serial_data_out_oe,
    // aux converter
    input wire logic [scp_pkg::AUX_W-1:0] aux_result,
    input wire logic aux_result_valid,
    input wire logic aux_conv_enable,
    input wire logic [scp_pkg::AUX_SEL_W-1:0] aux_converter_input
);
    import scp_pkg::*;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic rd_ff;
    logic nxt_rd;
    wire logic oe = sdio_oe | serial_data_out_oe;
    wire logic off = !rstn || spi_csn;
    ////////////////////////////////////////
    // rising edges seen so far in the frame, and its direction bit
    always_comb
    begin
        nxt_cnt = (cnt_ff == CNT_LAST) ? cnt_ff : cnt_ff + 5'h01;
        nxt_rd = (cnt_ff == 5'h00) ? sdio_in : rd_ff;
    end
    always_ff @(posedge spi_sclk or posedge spi_csn or negedge rstn)
    begin
        if (!rstn || spi_csn)
        begin
            cnt_ff <= 5'h00;
            rd_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            rd_ff <= nxt_rd;
        end
    end
    ////////////////////////////////////////
    AST_ONE_PIN: assert property (@(posedge spi_sclk) disable iff (off) !(sdio_oe && serial_data_out_oe))
        else $error("both data pins driven");
    AST_SAME_BIT: assert property (@(posedge spi_sclk) disable iff (off) oe |-> serial_data_out_pin == sdio_out)
        else $error("pins carry different bits");
    AST_OE_WINDOW: assert property (@(posedge spi_sclk) disable iff (off) oe |-> cnt_ff >= 5'h10 && cnt_ff <= 5'h17)
        else $error("pin driven outside read data bits");
    AST_READ_DRIVES: assert property (@(posedge spi_sclk) disable iff (off) rd_ff && cnt_ff >= 5'h10 |-> oe)
        else $error("read data not driven");
    AST_WRITE_QUIET: assert property (@(posedge spi_sclk) disable iff (off) !rd_ff && cnt_ff != 5'h00 |-> !oe)
        else $error("pin driven in write frame");
    AST_OE_STEADY: assert property (@(posedge spi_sclk) disable iff (off)
        cnt_ff >= 5'h11 && cnt_ff <= 5'h17 |-> $stable(sdio_oe) && $stable(serial_data_out_oe))
        else $error("enable toggled within read data");
    AST_IDLE_OFF: assert property (@(posedge core_clk) disable iff (!rstn) spi_csn && $past(spi_csn) |-> !oe)
        else $error("pin driven while deselected");
    AST_SEL_RANGE: assert property (@(posedge core_clk) disable iff (!rstn) aux_converter_input <= AUX_SEL_TEMP)
        else $error("selector out of range");
endmodule : scp_chk
bind scp_top scp_chk CHK (.core_clk(core_clk), .rstn(rstn), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_data_out_pin(serial_data_out_pin),
    .serial_data_out_oe(serial_data_out_oe), .aux_result(aux_result), .aux_result_valid(aux_result_valid),
    .aux_conv_enable(aux_conv_enable), .aux_converter_input(aux_converter_input));
`default_nettype wire

// ### bench/scp_host.sv
// host model: frames transfers, clocks only within frames
// assumes the device drives on falling and samples on rising serial edges
`timescale 1ns/100ps
`default_nettype none
module scp_host (
    // host side
    output logic sclk,
    output logic csn,
    output wire logic sdio_wire,
    // device side
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic out_pin,
    input wire logic out_oe
);
    logic tw = 1'b0;
    logic host_bit = 1'b0;
    ////////////////////////////////////////
    assign sdio_wire = sdio_oe ? sdio_out : host_bit;
    initial
    begin
        sclk = 1'b0;
        // short select pulse at start gives the frame logic a clean clearing edge
        csn = 1'b0;
        #1 csn = 1'b1;
    end
    // released lines toggle so a stale bit never reads as valid
    task automatic xfer(input logic rd, input logic [10:0] addr, input logic [7:0] wd, input int nbits,
        output logic [7:0] rdat);
        logic [23:0] frame;
        frame = {rd, 4'h0, addr, wd};
        rdat = 8'h00;
        csn = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            host_bit = (rd && i >= 16) ? ~host_bit : frame[23-i];
            #32 sclk = 1'b1;
            rdat = {rdat[6:0], tw ? sdio_wire : (out_oe ? out_pin : ~out_pin)};
            #32 sclk = 1'b0;
        end
        #32 csn = 1'b1;
        host_bit = ~host_bit;
        #1000;
    endtask : xfer
endmodule : scp_host
`default_nettype wire

// ### bench/serial_control_port_bench.sv
// self-checking bench of the control port
// assumes scp_host as the serial master
`timescale 1ns/100ps
`default_nettype none
module serial_control_port_bench;
    import scp_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b1;
    logic [AUX_W-1:0] aux_result = 12'h000;
    logic aux_result_valid = 1'b0;
    wire logic sclk, csn, sdio, d_out, d_oe, pin, pin_oe, aux_en;
    wire logic [AUX_SEL_W-1:0] aux_sel;
    int err_count = 0;
    int checks_done = 0;
    integer seed = 83;
    logic [7:0] exp_mem [8];
    logic [7:0] rdat;
    logic [AUX_W-1:0] aux_v;
    ////////////////////////////////////////
    always #25 core_clk = ~core_clk;
    scp_top DUT (.core_clk(core_clk), .rstn(rstn), .spi_sclk(sclk), .spi_csn(csn), .sdio_in(sdio),
        .sdio_out(d_out), .sdio_oe(d_oe), .serial_data_out_pin(pin), .serial_data_out_oe(pin_oe),
        .aux_result(aux_result), .aux_result_valid(aux_result_valid), .aux_conv_enable(aux_en),
        .aux_converter_input(aux_sel));
    scp_host HOST (.sclk(sclk), .csn(csn), .sdio_wire(sdio), .sdio_out(d_out), .sdio_oe(d_oe),
        .out_pin(pin), .out_oe(pin_oe));
    ////////////////////////////////////////
    function automatic logic [2:0] exp_sel(input logic [2:0] s);
        return (s > AUX_SEL_TEMP) ? AUX_SEL_TEMP : s;
    endfunction : exp_sel
    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic rd_all(input string what);
        for (int i = 0; i < 8; i++)
        begin
            HOST.xfer(1'b1, 11'h100 + 11'(i), 8'h00, 24, rdat);
            check({4'h0, rdat}, {4'h0, exp_mem[i]}, what);
        end
    endtask : rd_all
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    initial
    begin
        // reset falls after time zero so the link flops see a clearing edge
        #2 rstn = 1'b0;
        repeat (8) @(posedge core_clk);
        #2 rstn = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            exp_mem[i] = 8'($random(seed));
            HOST.xfer(1'b0, 11'h100 + 11'(i), exp_mem[i], 24, rdat);
        end
        HOST.xfer(1'b0, 11'h100, ~exp_mem[0], 23, rdat);
        rd_all("four-wire read");
        HOST.xfer(1'b0, REG_PORT_CFG, 8'h01, 24, rdat);
        HOST.tw = 1'b1;
        HOST.xfer(1'b1, REG_PORT_CFG, 8'h00, 24, rdat);
        check({4'h0, rdat}, 12'h001, "mode readback");
        rd_all("three-wire read");
        for (int s = 0; s < 8; s++)
        begin
            HOST.xfer(1'b0, REG_AUX_CTRL, {4'h0, 3'(s), 1'b1}, 24, rdat);
            check({8'h00, aux_en, aux_sel}, {8'h00, 1'b1, exp_sel(3'(s))}, "aux control");
        end
        // two back-to-back results: the later one must be read
        repeat (2)
        begin
            aux_v = 12'($random(seed));
            @(posedge core_clk);
            #2 aux_result = aux_v;
            aux_result_valid = 1'b1;
            @(posedge core_clk);
            #2 aux_result_valid = 1'b0;
            aux_result = ~aux_v;
        end
        HOST.xfer(1'b1, REG_AUX_LO, 8'h00, 24, rdat);
        HOST.xfer(1'b1, REG_AUX_LO, 8'h00, 24, rdat);
        check({4'h0, rdat}, {4'h0, aux_v[7:0]}, "aux low");
        HOST.xfer(1'b1, REG_AUX_HI, 8'h00, 24, rdat);
        check({4'h0, rdat}, {8'h00, aux_v[11:8]}, "aux high");
        HOST.xfer(1'b0, REG_AUX_CTRL, 8'h00, 24, rdat);
        check({8'h00, aux_en, aux_sel}, 12'h000, "aux off");
        final_report();
    end
    initial
    begin
        #2000000;
        err_count++;
        final_report();
    end
endmodule : serial_control_port_bench
`default_nettype wire
